// ### hw/sbi_core.sv
// How it works
// - Bitwise transfer with arbitration, framing checks, stretching and timeout in hardware.
// - As master, SCL stays high for the minimum high time from the timer.
// - SCL low stretched until software answers; minimum low still enforced.
// - Stop keeps minimum delay from SCL high to SDA high.
// - Minimum bus-free delay between stop and next start.
// - Start keeps minimum delay from SDA falling to SCL falling.
// - Minimum phase times come from the timer's low three bits or a three-bit phase count.
// - Bus timer advances on the CPU clock.
// - Timer preload picked from four values by a two-bit prescale field.
// - Maximum-SCL-change timeout uses the full timer width.
// - Each SCL transition reloads the timer preset while enabled.
// - Timer runs only between a start and the following stop.
// - Timer carries after 1020 to 1023 cycles since the last SCL change.
// - Timer carry resets the interface and releases SCL.
// - Interrupt when both enables set and attention flag is set.
// - Control register at D8H, bit addressable, resets to 81H.
// - Control reads give status bits; writes are clear and command strobes.
// - Attention reads one whenever ready, arbitration lost, start or stop is set.
// - Ready sets on SCL rise except idle slave; next low stretched until cleared.
// - SDA driven low and arbitration loss flagged only while transmit-active.
// - Master sets on request with free bus; clears on loss or withdraw plus stop.
//
// Purpose: Single-bit, software-serviced two-wire serial interface with bus timer.
// Assumes: CPU drives one SFR access per cycle; pins are open drain.
// Notes:   Timer ticks once per core clock, one prescale step per tick.
`timescale 1ns/1ps
module sbi_core #(
   parameter int TIMER_W = sbi_pkg::TIMER_W
) (
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire sbi_pkg::sbi_sfr_req_t sfr_req,
   output logic [7:0]                 sfr_rdata,
   input  wire logic                  global_interrupt_enable,
   input  wire logic                  bus_interrupt_enable,
   output logic                       bus_irq,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   output sbi_pkg::sbi_pin_drive_t    pins
);

   // *******************************************************
   // State
   // *******************************************************
   typedef enum logic [2:0] {
      MS_IDLE, MS_START_HOLD, MS_LOW, MS_HIGH, MS_STOP_SETUP, MS_STOP_HOLD
   } sbi_mstate_t;

   typedef struct packed {
      sbi_mstate_t         ms;
      logic [TIMER_W-1:0]  timer;
      logic [2:0]          phase;
      logic                received_bit;
      logic                bit_ready_flag;
      logic                arbitration_lost_flag;
      logic                start_seen_flag;
      logic                stop_seen_flag;
      logic                master;
      logic                xmit_active;
      logic                tx_bit;
      logic                idle_slave;
      logic                in_frame;
      logic                rstart_req;
      logic                stop_req;
      logic [7:0]          cfg;
      logic                scl_q;
      logic                sda_q;
      logic                drive_scl_low;
      logic                drive_sda_low;
   } sbi_state_t;

   sbi_state_t st;
   sbi_state_t next_st;
   logic       scl_s;
   logic       sda_s;

   sbi_sync u_scl_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (scl_i),
      .level   (scl_s)
   );

   sbi_sync u_sda_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .pin     (sda_i),
      .level   (sda_s)
   );

   // *******************************************************
   // Decode and bus events
   // *******************************************************
   logic       wr_ctrl;
   logic       wr_cfg;
   logic       wr_data;
   logic       rd_data;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_ev;
   logic       stop_ev;
   logic       attention;
   logic       carry;
   logic       phase_done;
   logic       bus_enabled;
   logic       master_request;
   logic [9:0] preset;

   assign wr_ctrl  = sfr_req.wr && (sfr_req.addr == sbi_pkg::CTRL_ADDR);
   assign wr_cfg   = sfr_req.wr && (sfr_req.addr == sbi_pkg::CFG_ADDR);
   assign wr_data  = sfr_req.wr && (sfr_req.addr == sbi_pkg::DATA_ADDR);
   assign rd_data  = sfr_req.rd && (sfr_req.addr == sbi_pkg::DATA_ADDR);
   assign scl_rise = scl_s && !st.scl_q;
   assign scl_fall = !scl_s && st.scl_q;
   assign start_ev = scl_s && st.scl_q && st.sda_q && !sda_s;
   assign stop_ev  = scl_s && st.scl_q && !st.sda_q && sda_s;
   assign bus_enabled    = st.cfg[sbi_pkg::CFG_MASTER_REQUEST] || !st.idle_slave || st.in_frame;
   assign master_request = st.cfg[sbi_pkg::CFG_MASTER_REQUEST];
   assign attention = st.bit_ready_flag || st.arbitration_lost_flag
                   || st.start_seen_flag || st.stop_seen_flag;
   assign carry      = st.in_frame && (&st.timer);
   assign phase_done = (&st.timer[sbi_pkg::PHASE_W-1:0]) || (st.phase == 3'h7);

   always_comb begin
      unique case ({st.cfg[sbi_pkg::CFG_CT1], st.cfg[sbi_pkg::CFG_CT0]})
         2'b00:   preset = sbi_pkg::PRESET_0;
         2'b01:   preset = sbi_pkg::PRESET_1;
         2'b10:   preset = sbi_pkg::PRESET_2;
         default: preset = sbi_pkg::PRESET_3;
      endcase
   end

   // *******************************************************
   // Next state
   // *******************************************************
   always_comb begin
      next_st       = st;
      next_st.scl_q = scl_s;
      next_st.sda_q = sda_s;

      // Bus timer: clocked by core clock, preset on SCL change, held at the preset outside frames.
      if (!st.in_frame) begin
         next_st.timer = preset[TIMER_W-1:0];
      end else if (bus_enabled && (scl_rise || scl_fall)) begin
         next_st.timer = preset[TIMER_W-1:0];
      end else begin
         next_st.timer = st.timer + 1'b1;
      end
      if (phase_done) begin
         next_st.phase = 3'h7;
      end else begin
         next_st.phase = st.phase + 3'h1;
      end

      // Software writes: control bits are strobes, not stored values.
      if (wr_cfg) begin
         next_st.cfg = sfr_req.wdata;
      end
      if (wr_ctrl) begin
         if (sfr_req.wdata[sbi_pkg::BIT_RECEIVED_BIT_CXA]) next_st.xmit_active = 1'b0;
         if (sfr_req.wdata[sbi_pkg::BIT_ATN_IDLE]) next_st.idle_slave = 1'b1;
         if (sfr_req.wdata[sbi_pkg::BIT_BIT_READY_FLAG_CDR]) next_st.bit_ready_flag = 1'b0;
         if (sfr_req.wdata[sbi_pkg::BIT_ARL_CLEAR_ARBITRATION_LOST]) next_st.arbitration_lost_flag = 1'b0;
         if (sfr_req.wdata[sbi_pkg::BIT_STR_CLEAR_START_SEEN]) next_st.start_seen_flag = 1'b0;
         if (sfr_req.wdata[sbi_pkg::BIT_STP_CLEAR_STOP_SEEN]) next_st.stop_seen_flag = 1'b0;
         if (sfr_req.wdata[sbi_pkg::BIT_MST_SEND_REPEATED_START]) begin
            next_st.rstart_req  = 1'b1;
            next_st.xmit_active = 1'b1;
         end
         if (sfr_req.wdata[sbi_pkg::BIT_SEND_STOP]) begin
            next_st.stop_req    = 1'b1;
            next_st.xmit_active = 1'b1;
         end
      end
      if (wr_data) begin
         next_st.tx_bit         = sfr_req.wdata[7];
         next_st.xmit_active    = 1'b1;
         next_st.bit_ready_flag = 1'b0;
      end
      if (rd_data) begin
         next_st.xmit_active    = 1'b0;
         next_st.bit_ready_flag = 1'b0;
      end

      // Hardware sets win over software clears.
      if (scl_rise && !st.idle_slave) begin
         next_st.bit_ready_flag = 1'b1;
         next_st.received_bit   = sda_s;
         if (st.xmit_active && st.drive_sda_low == 1'b0 && !sda_s) begin
            next_st.arbitration_lost_flag = 1'b1;
         end
      end
      if (start_ev) begin
         next_st.in_frame = 1'b1;
         if (!st.idle_slave || st.master) next_st.start_seen_flag = 1'b1;
         if (st.xmit_active && !st.drive_sda_low && !st.rstart_req) begin
            next_st.arbitration_lost_flag = 1'b1;
         end
         next_st.idle_slave = 1'b0;
      end
      if (stop_ev) begin
         next_st.in_frame = 1'b0;
         if (!st.idle_slave || st.master) next_st.stop_seen_flag = 1'b1;
      end
      if (next_st.arbitration_lost_flag && !st.arbitration_lost_flag) begin
         next_st.xmit_active = 1'b0;
         next_st.master      = 1'b0;
      end

      // Master pin sequencer; every phase waits out the minimum time.
      unique case (st.ms)
         MS_IDLE: begin
            next_st.drive_scl_low = 1'b0;
            next_st.drive_sda_low = 1'b0;
            if (master_request && !st.in_frame && !stop_ev && phase_done && scl_s
                && sda_s) begin
               next_st.master        = 1'b1;
               next_st.drive_sda_low = 1'b1;
               next_st.phase         = 3'h0;
               next_st.ms            = MS_START_HOLD;
            end
            if (stop_ev || start_ev) next_st.phase = 3'h0;
         end
         MS_START_HOLD: begin
            if (phase_done) begin
               next_st.drive_scl_low = 1'b1;
               next_st.phase         = 3'h0;
               next_st.ms            = MS_LOW;
            end
         end
         MS_LOW: begin
            // SDA changes only while SCL is held low.
            next_st.drive_sda_low = st.xmit_active && (st.stop_req || st.rstart_req
                                    ? 1'b1 : !st.tx_bit);
            if (phase_done && !attention) begin
               next_st.drive_scl_low = 1'b0;
               next_st.phase         = 3'h0;
               next_st.ms            = st.stop_req ? MS_STOP_SETUP : MS_HIGH;
            end
         end
         MS_HIGH: begin
            if (st.rstart_req && scl_s && phase_done) begin
               next_st.drive_sda_low = 1'b1;
               next_st.rstart_req    = 1'b0;
               next_st.phase         = 3'h0;
               next_st.ms            = MS_START_HOLD;
            end else if (scl_s && phase_done && !st.rstart_req) begin
               next_st.drive_scl_low = 1'b1;
               next_st.phase         = 3'h0;
               next_st.ms            = MS_LOW;
            end else if (st.rstart_req && !st.drive_scl_low && !scl_s) begin
               next_st.phase = 3'h0;
            end
         end
         MS_STOP_SETUP: begin
            if (scl_s && phase_done) begin
               next_st.drive_sda_low = 1'b0;
               next_st.stop_req      = 1'b0;
               next_st.xmit_active   = 1'b0;
               if (!master_request) next_st.master = 1'b0;
               next_st.phase         = 3'h0;
               next_st.ms            = MS_STOP_HOLD;
            end
         end
         MS_STOP_HOLD: begin
            if (phase_done) next_st.ms = MS_IDLE;
         end
         default: next_st.ms = MS_IDLE;
      endcase
      if (!st.master && st.ms != MS_IDLE) begin
         // Lost arbitration: let go of both lines at once.
         next_st.ms            = MS_IDLE;
         next_st.drive_scl_low = 1'b0;
         next_st.drive_sda_low = 1'b0;
      end

      // Slave side stretches SCL low while ready is pending.
      // A device that wins mastership in this cycle keeps its start drive.
      if (!st.master && !next_st.master) begin
         next_st.drive_scl_low = scl_fall || (st.drive_scl_low && !scl_s)
                                 ? (st.bit_ready_flag && !st.idle_slave) : 1'b0;
         next_st.drive_sda_low = st.xmit_active && !st.tx_bit && !st.idle_slave;
      end

      if (carry) begin
         next_st                = st;
         next_st.timer          = preset[TIMER_W-1:0];
         next_st.phase          = 3'h0;
         next_st.ms             = MS_IDLE;
         next_st.bit_ready_flag = 1'b0;
         next_st.arbitration_lost_flag = 1'b0;
         next_st.start_seen_flag = 1'b0;
         next_st.stop_seen_flag  = 1'b0;
         next_st.master         = 1'b0;
         next_st.xmit_active    = 1'b0;
         next_st.rstart_req     = 1'b0;
         next_st.stop_req       = 1'b0;
         next_st.in_frame       = 1'b0;
         next_st.drive_scl_low  = 1'b0;
         next_st.drive_sda_low  = 1'b0;
         next_st.scl_q          = scl_s;
         next_st.sda_q          = sda_s;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st            <= '0;
         st.ms         <= MS_IDLE;
         st.received_bit <= sbi_pkg::CTRL_RESET[sbi_pkg::BIT_RECEIVED_BIT_CXA];
         st.master     <= 1'b0;
         st.idle_slave <= 1'b1;
         st.cfg        <= sbi_pkg::CFG_RESET;
         st.scl_q      <= 1'b1;
         st.sda_q      <= 1'b1;
         st.phase      <= 3'h7;
      end else begin
         st <= next_st;
      end
   end

   // *******************************************************
   // Outputs
   // *******************************************************
   always_comb begin
      sfr_rdata = 8'h00;
      if (sfr_req.addr == sbi_pkg::CTRL_ADDR) begin
         sfr_rdata = {st.received_bit, attention, st.bit_ready_flag,
                      st.arbitration_lost_flag, st.start_seen_flag, st.stop_seen_flag,
                      st.master, 1'b1};
      end else if (sfr_req.addr == sbi_pkg::CFG_ADDR) begin
         sfr_rdata = st.cfg;
      end else if (sfr_req.addr == sbi_pkg::DATA_ADDR) begin
         sfr_rdata = {st.received_bit, 7'h00};
      end
   end

   assign bus_irq     = global_interrupt_enable && bus_interrupt_enable && attention;
   assign pins.scl_o  = 1'b0;
   assign pins.scl_oe = st.drive_scl_low;
   assign pins.sda_o  = 1'b0;
   assign pins.sda_oe = st.drive_sda_low && st.xmit_active;

endmodule

// ### hw/sbi_pkg.sv
// Purpose: Shared constants and types for the single-bit two-wire serial interface.
// Assumes: 50 MHz core clock; one machine cycle per core clock.
// Notes:   Register offsets are special-function addresses.
package sbi_pkg;

   localparam logic [7:0] CTRL_ADDR   = 8'hD8;
   localparam logic [7:0] CFG_ADDR    = 8'hD9;
   localparam logic [7:0] DATA_ADDR   = 8'hDA;
   localparam logic [7:0] CTRL_RESET  = 8'h81;
   localparam logic [7:0] CFG_RESET   = 8'h00;

   // Control register bit positions (read meaning / write meaning).
   localparam int BIT_RECEIVED_BIT_CXA   = 7;
   localparam int BIT_ATN_IDLE   = 6;
   localparam int BIT_BIT_READY_FLAG_CDR   = 5;
   localparam int BIT_ARL_CLEAR_ARBITRATION_LOST   = 4;
   localparam int BIT_STR_CLEAR_START_SEEN   = 3;
   localparam int BIT_STP_CLEAR_STOP_SEEN   = 2;
   localparam int BIT_MST_SEND_REPEATED_START   = 1;
   localparam int BIT_SEND_STOP       = 0;

   // Configuration register fields.
   localparam int CFG_MASTER_REQUEST     = 6;
   localparam int CFG_CT1        = 1;
   localparam int CFG_CT0        = 0;

   // Bus timer.
   localparam int TIMER_W        = 10;
   localparam int PHASE_W        = 3;
   localparam logic [9:0] PRESET_0 = 10'h000;
   localparam logic [9:0] PRESET_1 = 10'h001;
   localparam logic [9:0] PRESET_2 = 10'h002;
   localparam logic [9:0] PRESET_3 = 10'h003;

   // Minimum bus phase time as printed; the bus standard reads it in microseconds.
   localparam int MIN_PHASE_NS   = 4700;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int MIN_PHASE_CYC  = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sbi_sfr_req_t;

   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } sbi_pin_drive_t;

endpackage

// ### hw/sbi_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for one pin.
// Assumes: Input is asynchronous to clk.
// Notes:   Stage one is read only by stage two.
`timescale 1ns/1ps
module sbi_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pin,
   output logic      level
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } sbi_sync_st_t;

   sbi_sync_st_t st;
   sbi_sync_st_t next_st;

   always_comb begin
      next_st     = st;
      next_st.s1  = pin;
      next_st.s2  = st.s1;
      next_st.s3  = st.s2;
      if (st.s2 == st.s3) begin
         next_st.lvl = st.s3;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st <= 4'hF;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.lvl;
endmodule

// ### bench/sbi_core_assertions.sv
// Purpose: Concurrent checks on the ports of the two-wire bit interface.
// Assumes: Pins are open drain with pull-ups; scl_i and sda_i are wire levels.
// Notes:   Phase counts use the raw wire, so they lag the design's own view.
`timescale 1ns/1ps
module sbi_core_assertions #(
   parameter int TIMER_W = sbi_pkg::TIMER_W
) (
   input wire logic                    clk,
   input wire logic                    reset_n,
   input wire sbi_pkg::sbi_sfr_req_t   sfr_req,
   input wire logic [7:0]              sfr_rdata,
   input wire logic                    global_interrupt_enable,
   input wire logic                    bus_interrupt_enable,
   input wire logic                    bus_irq,
   input wire logic                    scl_i,
   input wire logic                    sda_i,
   input wire sbi_pkg::sbi_pin_drive_t pins
);
   logic [TIMER_W:0] scl_cnt;
   logic [TIMER_W:0] sda_cnt;
   logic             scl_q;
   logic             sda_q;
   logic             ctrl_rd;

   assign ctrl_rd = sfr_req.addr == sbi_pkg::CTRL_ADDR;

   // Counters start saturated so a long-idle bus needs no history.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         scl_cnt <= '1;
         sda_cnt <= '1;
      end else begin
         scl_q   <= scl_i;
         sda_q   <= sda_i;
         scl_cnt <= (scl_i != scl_q) ? '0 : scl_cnt + (TIMER_W + 1)'(~&scl_cnt);
         sda_cnt <= (sda_i != sda_q) ? '0 : sda_cnt + (TIMER_W + 1)'(~&sda_cnt);
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   reset_val_a:
   assert property ($rose(reset_n) && ctrl_rd |-> sfr_rdata == sbi_pkg::CTRL_RESET)
      else $error("control reset value wrong");
   irq_gate_a:
   assert property (ctrl_rd |->
      bus_irq == (global_interrupt_enable && bus_interrupt_enable && sfr_rdata[6]))
      else $error("interrupt does not follow enables and attention");
   attention_sum_a:
   assert property (ctrl_rd |-> sfr_rdata[6] == (|sfr_rdata[5:2]))
      else $error("attention differs from flag sum");
   // An eight-cycle phase reads as six here: the counter restarts one edge after
   // the wire moves, and $past looks back one edge more.
   scl_high_a:
   assert property ($rose(pins.scl_oe) && $past(scl_i) |-> $past(scl_cnt) >= 6)
      else $error("clock high phase too short");
   start_hold_a:
   assert property ($rose(pins.scl_oe) && $past(scl_i) && !$past(sda_i)
      |-> $past(sda_cnt) >= 6) else $error("start hold too short");
   stop_setup_a:
   assert property ($fell(pins.sda_oe) && $past(scl_i) |-> $past(scl_cnt) >= 6)
      else $error("stop setup too short");
   bus_free_a:
   assert property ($rose(pins.sda_oe) && $past(scl_i) && $past(sda_i)
      |-> $past(sda_cnt) >= 6) else $error("bus free time too short");
   low_stretch_a:
   assert property (ctrl_rd && sfr_rdata[5] && $fell(scl_i) |-> ##[0:8] pins.scl_oe)
      else $error("clock low not stretched");
   hang_release_a:
   assert property (scl_cnt > 1040 |-> !pins.scl_oe)
      else $error("clock held past bus timeout");
endmodule

bind sbi_core sbi_core_assertions #(.TIMER_W(TIMER_W)) u_chk (
   .clk                     (clk),
   .reset_n                 (reset_n),
   .sfr_req                 (sfr_req),
   .sfr_rdata               (sfr_rdata),
   .global_interrupt_enable (global_interrupt_enable),
   .bus_interrupt_enable    (bus_interrupt_enable),
   .bus_irq                 (bus_irq),
   .scl_i                   (scl_i),
   .sda_i                   (sda_i),
   .pins                    (pins)
);

// ### bench/sbi_bus_peer.sv
// Purpose: Behavioural external master on the two-wire bus.
// Assumes: Both lines have pull-ups; oe high pulls the line low.
// Notes:   Clock half period is 80 ns; it waits out a clock stretch of up to 5000 ns.
`timescale 1ns/1ps
module sbi_bus_peer (
   input  wire logic scl,
   input  wire logic sda,
   output logic      scl_oe,
   output logic      sda_oe
);
   localparam time HALF = 80;

   initial begin
      scl_oe = 1'b0;
      sda_oe = 1'b0;
   end

   task automatic wait_scl_high();
      int n;
      n = 0;
      while (!scl && n < 500) begin
         #10;
         n++;
      end
   endtask

   task automatic start();
      sda_oe = 1'b1;
      #HALF;
      scl_oe = 1'b1;
      #HALF;
   endtask

   task automatic send_bit(input logic b);
      sda_oe = !b;
      #HALF;
      scl_oe = 1'b0;
      wait_scl_high();
      #HALF;
      scl_oe = 1'b1;
      #HALF;
   endtask

   task automatic stop();
      sda_oe = 1'b1;
      #HALF;
      scl_oe = 1'b0;
      wait_scl_high();
      #HALF;
      sda_oe = 1'b0;
      #HALF;
   endtask
endmodule

// ### bench/testbench.sv
// Purpose: Self-checking bench for the two-wire bit interface.
// Assumes: 50 MHz clock; an external master model shares the wires.
// Notes:   Random data bits and prescale come from a fixed seed.
`timescale 1ns/1ps
module testbench;
   logic                    clk;
   logic                    reset_n;
   sbi_pkg::sbi_sfr_req_t   sfr_req;
   logic [7:0]              sfr_rdata;
   logic                    gie;
   logic                    bie;
   logic                    bus_irq;
   sbi_pkg::sbi_pin_drive_t pins;
   logic                    p_scl_oe;
   logic                    p_sda_oe;
   wire                     scl;
   wire                     sda;
   int                      failures = 0;
   int                      check_count = 0;
   int                      cyc = 0;
   int                      seed;
   logic [7:0]              rd;
   logic [7:0]              presc;
   logic                    b;

   // Open-drain wires with pull-ups.
   assign scl = !(pins.scl_oe || p_scl_oe);
   assign sda = !(pins.sda_oe || p_sda_oe);

   sbi_core uut (
      .clk                     (clk),
      .reset_n                 (reset_n),
      .sfr_req                 (sfr_req),
      .sfr_rdata               (sfr_rdata),
      .global_interrupt_enable (gie),
      .bus_interrupt_enable    (bie),
      .bus_irq                 (bus_irq),
      .scl_i                   (scl),
      .sda_i                   (sda),
      .pins                    (pins)
   );
   sbi_bus_peer peer (
      .scl    (scl),
      .sda    (sda),
      .scl_oe (p_scl_oe),
      .sda_oe (p_sda_oe)
   );

   task automatic tally_and_finish();
      if (failures == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Whole-register writes only; the control register reads differently.
   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      sfr_req.addr = a;
      sfr_req.wdata = d;
      sfr_req.wr = 1'b1;
      @(posedge clk);
      #1;
      sfr_req.wr = 1'b0;
      sfr_req.addr = sbi_pkg::CTRL_ADDR;
   endtask

   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      #1;
      sfr_req.addr = a;
      sfr_req.rd = 1'b1;
      @(posedge clk);
      d = sfr_rdata;
      #1;
      sfr_req.rd = 1'b0;
      sfr_req.addr = sbi_pkg::CTRL_ADDR;
   endtask

   task automatic wait_oe(input logic v);
      int n;
      n = 0;
      while (pins.scl_oe !== v && n < 1200) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      seed = 64773;
      reset_n = 1'b0;
      sfr_req = '0;
      sfr_req.addr = sbi_pkg::CTRL_ADDR;
      gie = 1'b0;
      bie = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      reset_n = 1'b1;
      sfr_read(sbi_pkg::CTRL_ADDR, rd);
      check8("ctrl reset", sbi_pkg::CTRL_RESET, rd);
      sfr_read(sbi_pkg::CFG_ADDR, rd);
      check8("cfg reset", sbi_pkg::CFG_RESET, rd);
      sfr_read(8'hDB, rd);
      check8("unmapped", 8'h00, rd);
      presc = 8'($random(seed)) & 8'h03;
      sfr_write(sbi_pkg::CFG_ADDR, presc);
      sfr_read(sbi_pkg::CFG_ADDR, rd);
      check8("cfg", presc, rd);
      // First round wakes the idle slave; the second sees a start as non-idle.
      for (int r = 0; r < 2; r++) begin
         peer.start();
         sfr_read(sbi_pkg::CTRL_ADDR, rd);
         check8("start flags", (r == 1) ? 8'h48 : 8'h00, rd & 8'h7E);
         if (r == 1) begin
            for (int k = 0; k < 4; k++) begin
               @(posedge clk);
               #1;
               {gie, bie} = 2'(k);
               @(negedge clk);
               check8("irq", {7'h00, k == 3}, {7'h00, bus_irq});
            end
            sfr_write(sbi_pkg::CTRL_ADDR, 8'h08);
            sfr_read(sbi_pkg::CTRL_ADDR, rd);
            check8("clear start", 8'h00, rd & 8'h7E);
         end
         for (int i = 0; i < 4; i++) begin
            b = 1'($random(seed));
            peer.send_bit(b);
            sfr_read(sbi_pkg::CTRL_ADDR, rd);
            check8("bit ready", {b, 7'h60}, rd & 8'hE0);
            check8("stretch", 8'h01, {7'h00, pins.scl_oe});
            sfr_read(sbi_pkg::DATA_ADDR, rd);
            check8("bit data", {b, 7'h00}, rd);
            wait_oe(1'b0);
            check8("release", 8'h00, {7'h00, pins.scl_oe});
         end
         peer.stop();
         sfr_read(sbi_pkg::CTRL_ADDR, rd);
         check8("stop flags", 8'h64, rd & 8'h7E);
         sfr_write(sbi_pkg::CTRL_ADDR, 8'h3C);
         sfr_read(sbi_pkg::CTRL_ADDR, rd);
         check8("clear flags", 8'h00, rd & 8'h7E);
      end
      // The start needs transmit active; a one bit keeps SDA free while still a slave.
      sfr_write(sbi_pkg::DATA_ADDR, 8'h80);
      sfr_write(sbi_pkg::CFG_ADDR, 8'h40 | presc);
      wait_oe(1'b1);
      // SDA is let go one cycle into the low phase, so it is looked at at once.
      check8("start drive", 8'h01, {7'h00, pins.sda_oe});
      check8("drive level", 8'h00, {6'h00, pins.scl_o, pins.sda_o});
      sfr_read(sbi_pkg::CTRL_ADDR, rd);
      check8("master", 8'h02, rd & 8'h02);
      // Request withdrawn so the timeout reset does not re-arm mastership.
      sfr_write(sbi_pkg::CFG_ADDR, presc);
      wait_oe(1'b0);
      check8("hang release", 8'h00, {6'h00, pins.scl_oe, pins.sda_oe});
      sfr_read(sbi_pkg::CTRL_ADDR, rd);
      check8("hang master", 8'h00, rd & 8'h02);
      sfr_read(sbi_pkg::CFG_ADDR, rd);
      check8("cfg kept", presc, rd);
      tally_and_finish();
   end
endmodule
